// >>> dv/rcs_host_model.sv
// Purpose: apb host model driving the command sequencer registers
// Assumes: slave may insert any number of wait states
// Notes: random idle gaps make the host prompt or slow
`timescale 1ns/10ps
`default_nettype none
module rcs_host_model (
  input wire logic core_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // released lines show the inverse so stale values never look valid
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    repeat ($urandom_range(1, 0)) @(posedge core_clk);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// >>> dv/rcs_seq_monitor.sv
// Purpose: port-level assertions for the command sequencer
// Assumes: power-up lasts well over 190 cycles after rstn release
// Notes: bound to the top module below
`timescale 1ns/10ps
`default_nettype none
module rcs_seq_monitor (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic reset_powerdown_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_bit,
  input wire logic tx_active
);
  import rcs_pkg::*;
  logic [7:0] boot_cnt_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // saturating age since reset release, only restart by rstn is tracked
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      boot_cnt_r <= 8'h00;
    else if (boot_cnt_r != 8'hFF)
      boot_cnt_r <= boot_cnt_r + 8'h01;
  end
  ready_in_access_a: assert property (psel && penable |-> pready)
    else $error("pready low in access cycle");
  err_only_access_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access cycle");
  unmapped_error_a: assert property (psel && penable && paddr == 8'h14 |-> pslverr)
    else $error("unmapped access not refused");
  unmapped_zero_a: assert property (psel && penable && !pwrite && paddr == 8'h14 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  boot_refuse_a: assert property (boot_cnt_r < 8'd190 && psel && penable && (pwrite || paddr >= OFS_REDUNDANCY)
    |-> pslverr) else $error("access during power-up not refused");
  boot_read_a: assert property (boot_cnt_r < 8'd190 && psel && penable && !pwrite && paddr == OFS_COMMAND
    |-> !pslverr && prdata[5:0] == CMD_POWER_UP) else $error("power-up command not reported");
  cmd_stop_a: assert property (psel && penable && pwrite && paddr == OFS_COMMAND && tx_active
    |=> !tx_active && !tx_bit) else $error("transmit not stopped by command write");
  sof_start_a: assert property ($rose(tx_active) |-> (tx_active && tx_bit)[*8])
    else $error("frame does not open with start bit");
endmodule
bind rcs_sequencer rcs_seq_monitor mon (.core_clk(core_clk), .rstn(rstn), .reset_powerdown_pin(reset_powerdown_pin),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_bit(tx_bit), .tx_active(tx_active));
`default_nettype wire

// >>> dv/test_rcs_sequencer.sv
// Purpose: self-checking bench for the command sequencer
// Assumes: host model speaks apb, frames sampled mid-bit
// Notes: crc16 and crc8 frames checked against a serial reference
`timescale 1ns/10ps
`default_nettype none
module test_rcs_sequencer;
  import rcs_pkg::*;
  logic core_clk, rstn, reset_powerdown_pin, psel, penable, pwrite, pready, pslverr, tx_bit, tx_active, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [63:0] got, expv;
  logic [15:0] d;
  int mismatches, cmp_count, cyc, n;
  // crc enable stays clear wherever a partial byte is set
  logic [3:0] redv [6] = '{4'h0, 4'h6, 4'h2, 4'h2, 4'h1, 4'hB};
  int lbv [6] = '{0, 0, 0, 5, 0, 0};
  rcs_sequencer uut (.core_clk(core_clk), .rstn(rstn), .reset_powerdown_pin(reset_powerdown_pin), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_bit(tx_bit), .tx_active(tx_active));
  rcs_host_model host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ****************************************
  // helpers
  // ****************************************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] m, input logic [31:0] e);
    cmp_count++;
    if ((g & m) !== e)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g & m, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v, rv, er);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, rv, er);
  endtask
  task automatic get_frame(input int nb);
    got = '0;
    for (int k = 0; k < 400 && tx_active !== 1'b1; k++) @(posedge core_clk);
    repeat (BIT_CYC / 2) @(posedge core_clk);
    for (int i = 0; i < nb; i++)
    begin
      got[i] = tx_bit;
      repeat (BIT_CYC) @(posedge core_clk);
    end
  endtask
  // serial lsb-first crc over both data bytes
  function automatic logic [15:0] crc_of(input logic [15:0] b, input logic c8);
    logic [15:0] c;
    c = c8 ? CRC8_PRESET : CRC16_PRESET;
    for (int i = 0; i < 16; i++)
    begin
      c = (c >> 1) ^ ((c[0] ^ b[i]) ? (c8 ? CRC8_POLY : CRC16_POLY) : 16'h0000);
    end
    return c;
  endfunction
  function automatic logic [63:0] frame(input logic [15:0] b, input logic [3:0] red, input int lb, output int len);
    logic [63:0] v;
    logic [31:0] s;
    int w;
    int nb;
    s = {crc_of(b, red[RC_CRC8]), b};
    nb = red[RC_TX_CRC] ? (red[RC_CRC8] ? 3 : 4) : 2;
    v = 64'h1;
    len = 1;
    for (int i = 0; i < nb; i++)
    begin
      w = (i == 1 && lb != 0) ? lb : 8;
      for (int j = 0; j < w; j++)
      begin
        v[len] = s[8*i+j];
        len++;
      end
      if (red[RC_PARITY] && w == 8)
      begin
        v[len] = ^s[8*i+:8] ^ red[RC_ODD];
        len++;
      end
    end
    v[len] = 1'b1;
    len++;
    return v;
  endfunction
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // hang guard, run needs about 14000 cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      mismatches++;
      stop_test();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rstn = 1'b0;
    reset_powerdown_pin = 1'b1;
    void'($urandom(78504));
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    rd(OFS_COMMAND);
    chk(rv, 32'h3F, 32'(CMD_POWER_UP));
    rd(OFS_MAIN_STATUS);
    chk(rv, 32'h20, 32'h20);
    wr(OFS_REDUNDANCY, 32'h0);
    chk({31'h0, er}, 32'h1, 32'h1);
    rd(OFS_REDUNDANCY);
    chk({31'h0, er}, 32'h1, 32'h1);
    for (int k = 0; k < 100; k++)
    begin
      rd(OFS_COMMAND);
      if (rv[5:0] == CMD_IDLE)
        break;
    end
    chk(rv, 32'h3F, 32'(CMD_IDLE));
    rd(OFS_MAIN_STATUS);
    chk(rv, 32'h28, 32'h08);
    rd(OFS_REDUNDANCY);
    chk(rv, 32'hF, 32'(EE_REDUNDANCY));
    rd(8'h14);
    chk({31'h0, er}, 32'h1, 32'h1);
    wr(8'h14, 32'h5A);
    chk({31'h0, er}, 32'h1, 32'h1);
    wr(OFS_FLAG_CLEAR, 32'h18);
    $display("power-up test done");
    for (int c = 0; c < 6; c++)
    begin
      d = 16'($urandom);
      wr(OFS_REDUNDANCY, 32'(redv[c]));
      wr(OFS_BIT_FRAMING, 32'(lbv[c]));
      if (c == 0)
      begin
        wr(OFS_COMMAND, 32'(CMD_TRANSMIT));
        rd(OFS_MAIN_STATUS);
        chk(rv, 32'h7, 32'(MP_WAIT));
      end
      wr(OFS_FIFO_DATA, 32'(d[7:0]));
      wr(OFS_FIFO_DATA, 32'(d[15:8]));
      if (c != 0)
        wr(OFS_COMMAND, 32'(CMD_TRANSMIT));
      expv = frame(d, redv[c], lbv[c], n);
      get_frame(n);
      chk(got[31:0], 32'hFFFFFFFF, expv[31:0]);
      chk(got[63:32], 32'hFFFFFFFF, expv[63:32]);
      chk({31'h0, tx_active}, 32'h1, 32'h0);
      rd(OFS_MAIN_STATUS);
      chk(rv, 32'h1F, 32'h18);
      rd(OFS_BIT_FRAMING);
      chk(rv, 32'h7, 32'h0);
      wr(OFS_FLAG_CLEAR, 32'h18);
      $display("frame test %0d done", c);
    end
    wr(OFS_REDUNDANCY, 32'h0);
    repeat (3) wr(OFS_FIFO_DATA, 32'($urandom_range(255, 0)));
    wr(OFS_COMMAND, 32'(CMD_TRANSMIT));
    for (int k = 0; k < 400 && tx_active !== 1'b1; k++) @(posedge core_clk);
    repeat (30) @(posedge core_clk);
    rd(OFS_MAIN_STATUS);
    chk(rv, 32'h7, 32'(MP_SOF));
    rd(OFS_FIFO_LEVEL);
    chk(rv, 32'h7F, 32'h3);
    wr(OFS_COMMAND, 32'(CMD_IDLE));
    repeat (2) @(posedge core_clk);
    chk({31'h0, tx_active}, 32'h1, 32'h0);
    rd(OFS_FIFO_LEVEL);
    chk(rv, 32'h7F, 32'h3);
    rd(OFS_MAIN_STATUS);
    chk(rv, 32'h18, 32'h0);
    $display("abort test done");
    reset_powerdown_pin <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(OFS_COMMAND);
    chk(rv, 32'h3F, 32'(CMD_POWER_UP));
    reset_powerdown_pin <= 1'b1;
    $display("restart test done");
    stop_test();
  end
endmodule
`default_nettype wire

// >>> hw/rcs_sequencer.sv
// Purpose: command sequencer with power-up, idle and transmit commands
// Assumes: inputs synchronous to core_clk; zero-wait APB slave
// Notes: frame is sof bit, data lsb first, parity, crc, eof bit
// Operation
// - power-up sequence command code 3Fh
// - power-up runs after reset, host cannot start
// - reset phase, then load nonvolatile register values
// - power-up completion enters idle command
// - during power-up only page 0 reads
// - idle code 00h cancels running command
// - self-completion returns idle, sets idle flag
// - host idle aborts without idle flag
// - abort leaves fifo contents intact
// - transmit code 1Ah, host-started, fifo to transmitter
// - transmit on empty fifo waits first byte
// - bytes written during transmit are appended
// - empty fifo at byte request ends transmit
// - finished transmission sets transmit-complete flag
// - command overwrite stops transmit next cycle
// - sof, data, eof; phase in status
// - crc and parity follow redundancy settings
// - partial last byte, no parity, count clears
`timescale 1ns/10ps
`default_nettype none
module rcs_sequencer (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic reset_powerdown_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tx_bit,
  output logic tx_active
);
  import rcs_pkg::*;

  // ****************************************
  // bus decode
  // ****************************************
  rcs_state_type state_r;
  logic in_power_up_sequence_cmd;
  logic wr_acc;
  logic rd_acc;
  logic page0;
  logic mapped;
  logic refused;
  assign in_power_up_sequence_cmd = (state_r == RCS_POWER_UP_SEQUENCE_CMD);
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign page0 = (paddr == OFS_COMMAND) | (paddr == OFS_FIFO_DATA) | (paddr == OFS_FIFO_LEVEL) |
                 (paddr == OFS_MAIN_STATUS) | (paddr == OFS_FLAG_CLEAR);
  assign mapped = page0 | (paddr == OFS_REDUNDANCY) | (paddr == OFS_BIT_FRAMING);
  // writes and page 1 reads are refused until the sequence is done
  assign refused = ~mapped | (in_power_up_sequence_cmd & (pwrite | ~page0));
  assign pready = 1'b1;
  assign pslverr = psel & penable & refused;

  logic cmd_wr;
  logic fifo_wr;
  logic cfg_wr;
  logic frm_wr;
  logic clr_wr;
  assign cmd_wr = wr_acc & ~refused & (paddr == OFS_COMMAND);
  assign cfg_wr = wr_acc & ~refused & (paddr == OFS_REDUNDANCY);
  assign frm_wr = wr_acc & ~refused & (paddr == OFS_BIT_FRAMING);
  assign clr_wr = wr_acc & ~refused & (paddr == OFS_FLAG_CLEAR);

  // ****************************************
  // fifo
  // ****************************************
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [5:0] wr_idx_r;
  logic [5:0] rd_idx_r;
  logic [6:0] level_r;
  logic fifo_empty;
  logic fifo_full;
  logic fifo_pop;
  assign fifo_empty = (level_r == 7'h00);
  assign fifo_full = (level_r == 7'(FIFO_DEPTH));
  assign fifo_wr = wr_acc & ~refused & (paddr == OFS_FIFO_DATA) & ~fifo_full;

  always_ff @(posedge core_clk)
  begin
    if (fifo_wr)
    begin
      fifo_mem[wr_idx_r] <= pwdata[7:0];
    end
  end

  // an abort never touches the pointers, so queued bytes survive
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_idx_r <= 6'h00;
      rd_idx_r <= 6'h00;
      level_r <= 7'h00;
    end
    else
    begin
      if (fifo_wr)
      begin
        wr_idx_r <= wr_idx_r + 6'h01;
      end
      if (fifo_pop)
      begin
        rd_idx_r <= rd_idx_r + 6'h01;
      end
      level_r <= level_r + {6'h00, fifo_wr} - {6'h00, fifo_pop};
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  logic [3:0] redundancy_config_reg;
  logic [2:0] last_byte_bit_count;
  logic load_nv;
  logic tx_done;
  logic [5:0] cmd_r;
  logic idle_completion_flag;
  logic tx_complete_flag;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      redundancy_config_reg <= 4'h0;
      last_byte_bit_count <= 3'h0;
    end
    else if (load_nv)
    begin
      redundancy_config_reg <= EE_REDUNDANCY;
      last_byte_bit_count <= EE_BIT_FRAMING;
    end
    else
    begin
      if (cfg_wr)
      begin
        redundancy_config_reg <= pwdata[3:0];
      end
      if (tx_done)
      begin
        last_byte_bit_count <= 3'h0;
      end
      else if (frm_wr)
      begin
        last_byte_bit_count <= pwdata[2:0];
      end
    end
  end

  // ****************************************
  // power-up sequence and bit clock
  // ****************************************
  logic pd_pin_r;
  logic pd_fall;
  logic [7:0] power_up_sequence_cmd_cnt_r;
  logic [7:0] bit_cnt_div_r;
  logic bit_tick;
  assign pd_fall = pd_pin_r & ~reset_powerdown_pin;
  assign load_nv = in_power_up_sequence_cmd & (power_up_sequence_cmd_cnt_r == 8'(RESET_PH_CYC));

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pd_pin_r <= 1'b1;
      power_up_sequence_cmd_cnt_r <= 8'h00;
    end
    else
    begin
      pd_pin_r <= reset_powerdown_pin;
      if (pd_fall)
      begin
        power_up_sequence_cmd_cnt_r <= 8'h00;
      end
      else if (in_power_up_sequence_cmd)
      begin
        power_up_sequence_cmd_cnt_r <= power_up_sequence_cmd_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bit_cnt_div_r <= 8'h00;
    end
    else if (state_r == RCS_IDLE || state_r == RCS_ARMED || bit_tick)
    begin
      bit_cnt_div_r <= 8'h00;
    end
    else
    begin
      bit_cnt_div_r <= bit_cnt_div_r + 8'h01;
    end
  end
  assign bit_tick = (bit_cnt_div_r == 8'(BIT_CYC - 1));

  // ****************************************
  // next byte selection
  // ****************************************
  logic [1:0] crc_ph_r;
  logic [15:0] crc_r;
  logic [15:0] crc_step;
  logic nx_eof;
  logic [7:0] nx_byte;
  logic [3:0] nx_len;
  logic [1:0] nx_ph;
  logic nx_partial;
  logic nx_pop;

  always_comb
  begin
    nx_eof = 1'b0;
    nx_byte = 8'h00;
    nx_len = 4'h8;
    nx_ph = crc_ph_r;
    nx_partial = 1'b0;
    nx_pop = 1'b0;
    if (crc_ph_r == 2'h0 && !fifo_empty)
    begin
      nx_pop = 1'b1;
      nx_byte = fifo_mem[rd_idx_r];
      if (level_r == 7'h01 && last_byte_bit_count != 3'h0)
      begin
        nx_len = {1'b0, last_byte_bit_count};
        nx_partial = 1'b1;
      end
    end
    else if (crc_ph_r == 2'h0 && redundancy_config_reg[RC_TX_CRC])
    begin
      // without parity the last data bit folds into the crc on this same tick
      nx_byte = (state_r == RCS_DATA) ? crc_step[7:0] : crc_r[7:0];
      nx_ph = 2'h1;
    end
    else if (crc_ph_r == 2'h1 && !redundancy_config_reg[RC_CRC8])
    begin
      nx_byte = crc_r[15:8];
      nx_ph = 2'h2;
    end
    else
    begin
      nx_eof = 1'b1;
    end
  end

  // ****************************************
  // command state machine and transmitter
  // ****************************************
  logic [7:0] shift_r;
  logic [3:0] bits_left_r;
  logic partial_r;
  logic par_r;
  logic tx_bit_r;
  logic crc_fb;
  logic [15:0] crc_poly;
  logic byte_end;
  assign crc_poly = redundancy_config_reg[RC_CRC8] ? CRC8_POLY : CRC16_POLY;
  assign crc_fb = crc_r[0] ^ shift_r[0];
  assign byte_end = (bits_left_r == 4'h1);
  assign fifo_pop = bit_tick & nx_pop &
                    ((state_r == RCS_SOF) | (state_r == RCS_PARITY) |
                     (state_r == RCS_DATA & byte_end &
                      ~(~partial_r & redundancy_config_reg[RC_PARITY] & crc_ph_r == 2'h0)));
  assign crc_step = (crc_r >> 1) ^ (crc_fb ? crc_poly : 16'h0000);
  assign tx_done = bit_tick & (state_r == RCS_EOF);

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= RCS_POWER_UP_SEQUENCE_CMD;
      cmd_r <= CMD_POWER_UP;
      shift_r <= 8'h00;
      bits_left_r <= 4'h0;
      partial_r <= 1'b0;
      par_r <= 1'b0;
      crc_ph_r <= 2'h0;
      crc_r <= 16'h0000;
      tx_bit_r <= 1'b0;
    end
    else if (pd_fall)
    begin
      state_r <= RCS_POWER_UP_SEQUENCE_CMD;
      cmd_r <= CMD_POWER_UP;
      tx_bit_r <= 1'b0;
    end
    else if (in_power_up_sequence_cmd)
    begin
      if (power_up_sequence_cmd_cnt_r == 8'(POWER_UP_SEQUENCE_CMD_CYC - 1))
      begin
        state_r <= RCS_IDLE;
        cmd_r <= CMD_IDLE;
      end
    end
    else if (cmd_wr)
    begin
      // power-up code from the host is not a command, it just idles
      tx_bit_r <= 1'b0;
      if (pwdata[5:0] == CMD_TRANSMIT)
      begin
        state_r <= RCS_ARMED;
        cmd_r <= CMD_TRANSMIT;
      end
      else
      begin
        state_r <= RCS_IDLE;
        cmd_r <= CMD_IDLE;
      end
    end
    else
    begin
      case (state_r)
        RCS_ARMED:
        begin
          if (!fifo_empty)
          begin
            state_r <= RCS_SOF;
            tx_bit_r <= 1'b1;
            crc_ph_r <= 2'h0;
            crc_r <= redundancy_config_reg[RC_CRC8] ? CRC8_PRESET : CRC16_PRESET;
          end
        end
        RCS_SOF, RCS_PARITY, RCS_DATA:
        begin
          if (bit_tick)
          begin
            if (state_r == RCS_DATA && crc_ph_r == 2'h0)
            begin
              crc_r <= crc_step;
            end
            if (state_r == RCS_DATA && !byte_end)
            begin
              tx_bit_r <= shift_r[1];
              shift_r <= {1'b0, shift_r[7:1]};
              bits_left_r <= bits_left_r - 4'h1;
              par_r <= par_r ^ shift_r[0];
            end
            else if (state_r == RCS_DATA && !partial_r && redundancy_config_reg[RC_PARITY])
            begin
              state_r <= RCS_PARITY;
              tx_bit_r <= par_r ^ shift_r[0] ^ redundancy_config_reg[RC_ODD];
            end
            else if (nx_eof)
            begin
              state_r <= RCS_EOF;
              tx_bit_r <= 1'b1;
            end
            else
            begin
              state_r <= RCS_DATA;
              shift_r <= nx_byte;
              tx_bit_r <= nx_byte[0];
              bits_left_r <= nx_len;
              partial_r <= nx_partial;
              crc_ph_r <= nx_ph;
              par_r <= 1'b0;
            end
          end
        end
        RCS_EOF:
        begin
          if (bit_tick)
          begin
            state_r <= RCS_IDLE;
            cmd_r <= CMD_IDLE;
            tx_bit_r <= 1'b0;
          end
        end
        default:
        begin
          tx_bit_r <= 1'b0;
        end
      endcase
    end
  end
  assign tx_bit = tx_bit_r;
  assign tx_active = (state_r == RCS_SOF) | (state_r == RCS_DATA) |
                     (state_r == RCS_PARITY) | (state_r == RCS_EOF);

  // ****************************************
  // completion flags
  // ****************************************
  logic idle_set;
  assign idle_set = tx_done | (in_power_up_sequence_cmd & ~pd_fall & (power_up_sequence_cmd_cnt_r == 8'(POWER_UP_SEQUENCE_CMD_CYC - 1)));

  // set wins over a simultaneous clear
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      idle_completion_flag <= 1'b0;
      tx_complete_flag <= 1'b0;
    end
    else
    begin
      if (idle_set)
      begin
        idle_completion_flag <= 1'b1;
      end
      else if (clr_wr && pwdata[ST_IDLE_FLAG])
      begin
        idle_completion_flag <= 1'b0;
      end
      if (tx_done)
      begin
        tx_complete_flag <= 1'b1;
      end
      else if (clr_wr && pwdata[ST_TX_FLAG])
      begin
        tx_complete_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // read data
  // ****************************************
  logic [2:0] modem_phase_field;
  logic [7:0] main_status_reg;
  always_comb
  begin
    case (state_r)
      RCS_ARMED: modem_phase_field = MP_WAIT;
      RCS_SOF: modem_phase_field = MP_SOF;
      RCS_DATA, RCS_PARITY: modem_phase_field = MP_DATA;
      RCS_EOF: modem_phase_field = MP_EOF;
      default: modem_phase_field = MP_IDLE;
    endcase
  end
  assign main_status_reg = {fifo_full, fifo_empty, in_power_up_sequence_cmd, tx_complete_flag,
                            idle_completion_flag, modem_phase_field};

  // captured in the setup cycle, shown in the access cycle
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= 32'h00000000;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h00000000;
      if (!(in_power_up_sequence_cmd && !page0))
      begin
        case (paddr)
          OFS_COMMAND: prdata <= {26'h0000000, cmd_r};
          OFS_FIFO_LEVEL: prdata <= {25'h0000000, level_r};
          OFS_MAIN_STATUS: prdata <= {24'h000000, main_status_reg};
          OFS_REDUNDANCY: prdata <= {28'h0000000, redundancy_config_reg};
          OFS_BIT_FRAMING: prdata <= {29'h00000000, last_byte_bit_count};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> shared/rcs_pkg.sv
// Purpose: constants for the reader command sequencer (transmit path)
// Assumes: 10 MHz core clock, APB register access
// Notes: offsets are byte addresses of 32-bit words
package rcs_pkg;
  localparam int CLK_NS = 100;
  localparam int BIT_NS = 9400;
  localparam int BIT_CYC = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int POWER_UP_SEQUENCE_CMD_NS = 20000;
  localparam int POWER_UP_SEQUENCE_CMD_CYC = (POWER_UP_SEQUENCE_CMD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_PH_CYC = 4;
  localparam int FIFO_DEPTH = 64;
  // command codes
  localparam logic [5:0] CMD_IDLE = 6'h00;
  localparam logic [5:0] CMD_TRANSMIT = 6'h1A;
  localparam logic [5:0] CMD_POWER_UP = 6'h3F;
  // page 0 register offsets
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_FIFO_DATA = 8'h04;
  localparam logic [7:0] OFS_FIFO_LEVEL = 8'h08;
  localparam logic [7:0] OFS_MAIN_STATUS = 8'h0C;
  localparam logic [7:0] OFS_FLAG_CLEAR = 8'h10;
  // page 1 register offsets
  localparam logic [7:0] OFS_REDUNDANCY = 8'h20;
  localparam logic [7:0] OFS_BIT_FRAMING = 8'h24;
  // redundancy_config_reg fields
  localparam int RC_TX_CRC = 0;
  localparam int RC_PARITY = 1;
  localparam int RC_ODD = 2;
  localparam int RC_CRC8 = 3;
  // main_status_reg fields
  localparam int ST_IDLE_FLAG = 3;
  localparam int ST_TX_FLAG = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_EMPTY = 6;
  localparam int ST_FULL = 7;
  // modem_phase_field encodings
  localparam logic [2:0] MP_IDLE = 3'h0;
  localparam logic [2:0] MP_WAIT = 3'h1;
  localparam logic [2:0] MP_SOF = 3'h2;
  localparam logic [2:0] MP_DATA = 3'h3;
  localparam logic [2:0] MP_EOF = 3'h4;
  // nonvolatile values applied in the initialization phase
  localparam logic [3:0] EE_REDUNDANCY = 4'h3;
  localparam logic [2:0] EE_BIT_FRAMING = 3'h0;
  // crc settings, serial lsb-first
  localparam logic [15:0] CRC16_PRESET = 16'h6363;
  localparam logic [15:0] CRC16_POLY = 16'h8408;
  localparam logic [15:0] CRC8_PRESET = 16'h00FF;
  localparam logic [15:0] CRC8_POLY = 16'h00B8;
  typedef enum logic [2:0] {
    RCS_POWER_UP_SEQUENCE_CMD, RCS_IDLE, RCS_ARMED, RCS_SOF, RCS_DATA, RCS_PARITY, RCS_EOF
  } rcs_state_type;
endpackage
